// *** design/fdl_regs.svh ***
// Register offsets, field positions and constants of the transmit decoder
`ifndef FDL_REGS_SVH
`define FDL_REGS_SVH

// Register offsets
`define FDL_OFS_FIFO 8'h00
`define FDL_OFS_STAT 8'h01
`define FDL_OFS_CTRL 8'h02
`define FDL_OFS_CMD 8'h07

// Handshake command bit positions
`define FDL_CMD_MSG_END 0
`define FDL_CMD_TRANSP 1
`define FDL_CMD_HDLC 2
`define FDL_CMD_ODD 3
`define FDL_CMD_REPEAT 4
`define FDL_CMD_TX_RESET 5
`define FDL_CMD_ABORT 6
`define FDL_CMD_RX_DONE 8

// Control register
`define FDL_CTRL_CRC_BIT 0
`define FDL_CTRL_RESET 1'b1

// Status word abort indication position
`define FDL_STAT_ABORT_BIT 0

// Line codes and CRC
`define FDL_FLAG 8'h7e
`define FDL_ABORT_SEQ 8'h7f
`define FDL_CRC_INIT 16'hffff
`define FDL_CRC_POLY 16'h8408
`define FDL_ONES_MAX 3'h5

`endif

// *** design/fdl_pkg.sv ***
// Types of the transmit command decoder
package fdl_pkg;

	typedef enum logic [7:0] {
		FDL_IDLE = 8'h01,
		FDL_OPEN = 8'h02,
		FDL_DATA = 8'h04,
		FDL_TAIL = 8'h08,
		FDL_CRC_LO = 8'h10,
		FDL_CRC_HI = 8'h20,
		FDL_CLOSE = 8'h40,
		FDL_ABORT = 8'h80
	} fdl_state_type;

	typedef struct packed {
		fdl_state_type st;
		logic [7:0] sh;
		logic [3:0] nb;
		logic [2:0] ones;
		logic stuf;
		logic crc_on;
		logic [15:0] crc;
		logic bit_out;
		logic bit_vld;
		logic [7:0] hi_byte;
		logic hi_pend;
		logic fin;
		logic hdlc;
		logic rep;
		logic endm;
		logic odd;
		logic abt;
		logic crc_en;
		logic undr;
		logic rx_rel;
		logic [15:0] rdata;
	} fdl_state_rec_type;

endpackage

// *** design/fdl_tx_cmd.sv ***
// Transmit command decoder, framer engine and transmit FIFO
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "fdl_regs.svh"

module fdl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_last,
	input wire logic keep,
	input wire logic rewind,
	input wire logic release_blk,
	input wire logic flush,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
		logic [AW:0] base;
	} fdl_fifo_rec_type;
	fdl_fifo_rec_type f_reg, f_next;

	// Base pointer holds kept words so a block can be replayed
	assign level = f_reg.wr - f_reg.base;
	assign in_ready = level != (AW+1)'(DEPTH);
	assign out_valid = f_reg.rd != f_reg.wr;
	assign out_last = (f_reg.wr - f_reg.rd) == (AW+1)'(1);
	assign out_data = f_reg.mem[f_reg.rd[AW-1:0]];

	// Pointer moves, flush above rewind above pop
	always_comb begin
		f_next = f_reg;
		if (in_valid && in_ready) begin
			f_next.mem[f_reg.wr[AW-1:0]] = in_data;
			f_next.wr = f_reg.wr + (AW+1)'(1);
		end
		if (flush) begin
			f_next.rd = f_reg.wr;
			f_next.base = f_reg.wr;
		end else if (rewind) begin
			f_next.rd = f_reg.base;
		end else if (release_blk) begin
			f_next.base = f_reg.rd;
		end else if (out_ready && out_valid) begin
			f_next.rd = f_reg.rd + (AW+1)'(1);
			if (!keep)
				f_next.base = f_next.rd;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			f_reg.wr <= '0;
			f_reg.rd <= '0;
			f_reg.base <= '0;
			f_reg.mem <= f_next.mem;
		end else begin
			f_reg <= f_next;
		end
	end
endmodule

module fdl_tx_cmd #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic link_take,
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic tx_fifo_ready,
	output logic rx_release_pulse
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	fdl_pkg::fdl_state_rec_type r_reg, r_next;
	logic fifo_wr, f_valid, f_pop, f_last, f_rew, f_rel, f_flush;
	logic [15:0] f_data;
	logic [LW-1:0] f_level;
	logic cmd_wr, tx_ok, start, ser_busy, sm, fin, b;
	logic reg_wr_ctrl_c;
	logic [15:0] w;

	assign fifo_wr = reg_wr && reg_addr == `FDL_OFS_FIFO;

	// Repeat modes keep the block in the FIFO for replay
	fdl_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(fifo_wr),
		.in_ready(tx_fifo_ready),
		.in_data(reg_wdata),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data),
		.out_last(f_last),
		.keep(r_reg.rep),
		.rewind(f_rew),
		.release_blk(f_rel),
		.flush(f_flush),
		.level(f_level)
	);

	// Decode of a handshake write, low byte dropped with receive bit
	assign cmd_wr = reg_wr && reg_addr == `FDL_OFS_CMD;
	assign tx_ok = cmd_wr && !reg_wdata[`FDL_CMD_RX_DONE];
	assign start = tx_ok && !reg_wdata[`FDL_CMD_TX_RESET] &&
		(reg_wdata[`FDL_CMD_HDLC] ^ reg_wdata[`FDL_CMD_TRANSP]);
	// A pending stuff bit keeps the serializer busy across bytes
	assign ser_busy = r_reg.nb != 4'h0 ||
		(r_reg.stuf && r_reg.ones == `FDL_ONES_MAX);
	assign sm = r_reg.hdlc && r_reg.endm && !r_reg.rep;
	assign fin = f_last && (r_reg.endm || r_reg.rep);
	assign tx_bit = r_reg.bit_out;
	assign tx_bit_valid = r_reg.bit_vld;
	assign reg_rdata = r_reg.rdata;
	assign rx_release_pulse = r_reg.rx_rel;

	always_comb begin
		r_next = r_reg;
		f_pop = 1'b0;
		f_rew = 1'b0;
		f_rel = 1'b0;
		f_flush = 1'b0;
		b = r_reg.sh[0];
		w = f_data;
		r_next.bit_vld = 1'b0;
		r_next.rx_rel = cmd_wr && reg_wdata[`FDL_CMD_RX_DONE];
		r_next.undr = 1'b0;
		// Serializer: stuffing only while stuf is set
		if (link_take && ser_busy) begin
			r_next.bit_vld = 1'b1;
			if (r_reg.stuf && r_reg.ones == `FDL_ONES_MAX) begin
				r_next.bit_out = 1'b0;
				r_next.ones = 3'h0;
			end else begin
				r_next.bit_out = b;
				r_next.sh = {1'b0, r_reg.sh[7:1]};
				r_next.nb = r_reg.nb - 4'h1;
				r_next.ones = (r_reg.stuf && b) ? r_reg.ones + 3'h1 : 3'h0;
				if (r_reg.crc_on)
					r_next.crc = {1'b0, r_reg.crc[15:1]} ^
						((r_reg.crc[0] ^ b) ? `FDL_CRC_POLY : 16'h0000);
			end
		end
		// Byte loader, one byte per idle serializer
		if (!ser_busy) begin
			case (r_reg.st)
			fdl_pkg::FDL_IDLE: begin
			end
			fdl_pkg::FDL_OPEN: begin
				r_next.sh = `FDL_FLAG;
				r_next.nb = 4'h8;
				r_next.stuf = 1'b0;
				r_next.ones = 3'h0;
				r_next.crc_on = 1'b0;
				r_next.crc = `FDL_CRC_INIT;
				r_next.st = fdl_pkg::FDL_DATA;
			end
			fdl_pkg::FDL_DATA: begin
				if (r_reg.hi_pend) begin
					r_next.sh = r_reg.hi_byte;
					r_next.nb = 4'h8;
					r_next.hi_pend = 1'b0;
					if (r_reg.fin)
						r_next.st = fdl_pkg::FDL_TAIL;
				end else if (f_valid) begin
					f_pop = 1'b1;
					r_next.fin = fin;
					r_next.hi_byte = w[15:8];
					if (fin && sm && r_reg.odd) begin
						// Status alone in the low byte, nothing sent
						r_next.abt = w[`FDL_STAT_ABORT_BIT];
						r_next.st = fdl_pkg::FDL_TAIL;
					end else begin
						r_next.sh = w[7:0];
						r_next.nb = 4'h8;
						r_next.stuf = r_reg.hdlc;
						r_next.crc_on = r_reg.hdlc;
						r_next.hi_pend = !(fin && (r_reg.odd || sm));
						if (fin && sm)
							r_next.abt = w[8+`FDL_STAT_ABORT_BIT];
						if (fin && !r_next.hi_pend)
							r_next.st = fdl_pkg::FDL_TAIL;
					end
				end else if (!fin) begin
					r_next.undr = 1'b1;
				end
			end
			fdl_pkg::FDL_TAIL: begin
				if (r_reg.hdlc) begin
					if (r_reg.abt)
						r_next.st = fdl_pkg::FDL_ABORT;
					else if (r_reg.crc_en)
						r_next.st = fdl_pkg::FDL_CRC_LO;
					else
						r_next.st = fdl_pkg::FDL_CLOSE;
				end else if (r_reg.rep && !r_reg.endm) begin
					f_rew = 1'b1;
					r_next.st = fdl_pkg::FDL_DATA;
				end else begin
					f_rel = 1'b1;
					r_next.st = fdl_pkg::FDL_IDLE;
				end
			end
			fdl_pkg::FDL_CRC_LO: begin
				r_next.sh = ~r_reg.crc[7:0];
				r_next.nb = 4'h8;
				r_next.crc_on = 1'b0;
				r_next.st = fdl_pkg::FDL_CRC_HI;
			end
			fdl_pkg::FDL_CRC_HI: begin
				r_next.sh = ~r_reg.crc[15:8];
				r_next.nb = 4'h8;
				r_next.st = fdl_pkg::FDL_CLOSE;
			end
			fdl_pkg::FDL_CLOSE: begin
				r_next.sh = `FDL_FLAG;
				r_next.nb = 4'h8;
				r_next.stuf = 1'b0;
				r_next.ones = 3'h0;
				if (r_reg.rep && !r_reg.endm) begin
					f_rew = 1'b1;
					r_next.st = fdl_pkg::FDL_OPEN;
				end else begin
					f_rel = 1'b1;
					r_next.st = fdl_pkg::FDL_IDLE;
				end
			end
			fdl_pkg::FDL_ABORT: begin
				r_next.sh = `FDL_ABORT_SEQ;
				r_next.nb = 4'h8;
				r_next.stuf = 1'b0;
				r_next.crc_on = 1'b0;
				f_rel = 1'b1;
				r_next.st = fdl_pkg::FDL_IDLE;
			end
			default: begin
				r_next.st = fdl_pkg::FDL_IDLE;
			end
			endcase
		end
		// Commands act once, in the write cycle only
		if (tx_ok && reg_wdata[`FDL_CMD_TX_RESET]) begin
			r_next.st = fdl_pkg::FDL_IDLE;
			r_next.nb = 4'h0;
			r_next.ones = 3'h0;
			r_next.stuf = 1'b0;
			r_next.crc_on = 1'b0;
			r_next.hi_pend = 1'b0;
			r_next.rep = 1'b0;
			r_next.endm = 1'b0;
			r_next.hdlc = 1'b0;
			f_flush = 1'b1;
		end else if (tx_ok && reg_wdata[`FDL_CMD_ABORT] &&
			r_reg.hdlc && r_reg.st != fdl_pkg::FDL_IDLE) begin
			// Cut the byte in flight so the abort goes out at once
			r_next.st = fdl_pkg::FDL_ABORT;
			r_next.nb = 4'h0;
			r_next.ones = 3'h0;
			r_next.stuf = 1'b0;
			r_next.hi_pend = 1'b0;
			f_flush = 1'b1;
		end else if (start && r_reg.st == fdl_pkg::FDL_IDLE) begin
			r_next.hdlc = reg_wdata[`FDL_CMD_HDLC];
			r_next.rep = reg_wdata[`FDL_CMD_REPEAT];
			r_next.endm = reg_wdata[`FDL_CMD_MSG_END];
			r_next.odd = reg_wdata[`FDL_CMD_ODD];
			r_next.abt = 1'b0;
			r_next.fin = 1'b0;
			r_next.hi_pend = 1'b0;
			// A frame closed without CRC leaves crc_on set
			r_next.stuf = 1'b0;
			r_next.crc_on = 1'b0;
			r_next.st = reg_wdata[`FDL_CMD_HDLC] ?
				fdl_pkg::FDL_OPEN : fdl_pkg::FDL_DATA;
		end else if (start && reg_wdata[`FDL_CMD_MSG_END]) begin
			// Late message end, or stop of a running repeat
			r_next.endm = 1'b1;
			r_next.odd = reg_wdata[`FDL_CMD_ODD];
		end
		if (reg_wr && reg_addr == `FDL_OFS_CTRL)
			r_next.crc_en = reg_wdata[`FDL_CTRL_CRC_BIT];
		// Read data stands for the one cycle after the strobe
		r_next.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
			`FDL_OFS_STAT:
				r_next.rdata = (16'(f_level) << 8) |
					{10'h000, !tx_fifo_ready, r_reg.undr, r_reg.endm,
					r_reg.rep, r_reg.hdlc,
					r_reg.st != fdl_pkg::FDL_IDLE};
			`FDL_OFS_CTRL:
				r_next.rdata = {15'h0000, r_reg.crc_en};
			default: begin
				r_next.rdata = 16'h0000;
			end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.st <= fdl_pkg::FDL_IDLE;
			r_reg.crc <= `FDL_CRC_INIT;
			r_reg.crc_en <= `FDL_CTRL_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	assign reg_wr_ctrl_c = reg_wr && reg_addr == `FDL_OFS_CTRL;

	rx_cancel_a: assert property (
		cmd_wr && reg_wdata[`FDL_CMD_RX_DONE]
		&& r_reg.st == fdl_pkg::FDL_IDLE
		|=> r_reg.st == fdl_pkg::FDL_IDLE)
		else $error("transmit started despite receive complete");

	tx_reset_a: assert property (
		tx_ok && reg_wdata[`FDL_CMD_TX_RESET] && !reg_wr_ctrl_c
		|=> r_reg.st == fdl_pkg::FDL_IDLE && $stable(r_reg.crc_en)
			&& r_reg.nb == 4'h0)
		else $error("transmitter reset not applied");

	abort_cmd_a: assert property (
		tx_ok && reg_wdata[`FDL_CMD_ABORT] && !reg_wdata[`FDL_CMD_TX_RESET]
		&& r_reg.hdlc && r_reg.st != fdl_pkg::FDL_IDLE
		|=> r_reg.st == fdl_pkg::FDL_ABORT ##1 r_reg.sh == `FDL_ABORT_SEQ)
		else $error("abort command ignored");

	hdlc_open_a: assert property (
		start && reg_wdata[`FDL_CMD_HDLC] && r_reg.st == fdl_pkg::FDL_IDLE
		|=> r_reg.st == fdl_pkg::FDL_OPEN && r_reg.hdlc)
		else $error("HDLC command did not open a frame");

	transp_raw_a: assert property (
		!r_reg.hdlc && r_reg.st == fdl_pkg::FDL_DATA
		|-> !r_reg.stuf && !r_reg.crc_on)
		else $error("transparent data stuffed or checksummed");

	status_abort_a: assert property (
		r_reg.st == fdl_pkg::FDL_TAIL && !ser_busy && r_reg.hdlc
		&& !tx_ok
		|=> r_reg.st == (r_reg.abt ? fdl_pkg::FDL_ABORT :
			($past(r_reg.crc_en) ? fdl_pkg::FDL_CRC_LO : fdl_pkg::FDL_CLOSE)))
		else $error("frame end did not follow status word");

	repeat_loop_a: assert property (
		r_reg.st == fdl_pkg::FDL_CLOSE && !ser_busy && r_reg.rep
		&& !r_reg.endm && !tx_ok
		|-> f_rew ##1 r_reg.st == fdl_pkg::FDL_OPEN)
		else $error("repeat frame not restarted");

	odd_low_a: assert property (
		f_pop && fin && r_reg.odd && r_reg.st == fdl_pkg::FDL_DATA && !tx_ok
		|=> !r_reg.hi_pend)
		else $error("high byte of odd final word kept");

	no_hold_a: assert property (
		r_reg.st == fdl_pkg::FDL_IDLE && !cmd_wr
		|=> r_reg.st == fdl_pkg::FDL_IDLE)
		else $error("command acted without a write");
endmodule

// *** test/fdl_tx_cmd_tb.sv ***
// Self-checking bench of the transmit command decoder
`timescale 1ns/1ps
`include "fdl_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module fdl_tx_cmd_tb;
	typedef struct packed {
		logic [15:0] cmd;
		logic [15:0] word;
		logic ctrl;
		logic [1:0] nb;
		logic [1:0] kind;
		logic [1:0] reps;
		logic ex;
		logic [5:0] lvl;
	} fdl_row_type;

	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic link_take = 1'b0;
	logic [15:0] reg_rdata;
	logic tx_bit;
	logic tx_bit_valid;
	logic tx_fifo_ready;
	logic rx_release_pulse;
	int mismatches = 0;
	int compares = 0;
	int rx_cnt = 0;
	int c_n = 0;
	int e_n;
	int ones;
	logic [127:0] c_v = '0;
	logic [127:0] e_v;
	logic [15:0] crc;
	logic [15:0] rv;
	logic [7:0] b;
	logic fb;
	logic seen;
	fdl_row_type r;
	fdl_row_type rows [10];
	logic [15:0] stp [2];

	always #2.5 clk_sys = ~clk_sys;

	fdl_tx_cmd #(.FIFO_DEPTH(32)) i_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.link_take(link_take),
		.tx_bit(tx_bit),
		.tx_bit_valid(tx_bit_valid),
		.tx_fifo_ready(tx_fifo_ready),
		.rx_release_pulse(rx_release_pulse)
	);

	// Line capture; bits land at the edge after their valid pulse
	always @(posedge clk_sys) begin
		if (tx_bit_valid === 1'b1) begin
			if (c_n < 128)
				c_v[c_n] = tx_bit;
			c_n++;
		end
		if (rx_release_pulse === 1'b1)
			rx_cnt++;
	end

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Offset keeps the clear away from the capture process
	task clr;
		#1 c_n = 0;
		c_v = '0;
		rx_cnt = 0;
	endtask

	task coll(input int n);
		@(posedge clk_sys);
		link_take <= 1'b1;
		repeat (n) @(posedge clk_sys);
		link_take <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask

	// Stuffing counts ones across data and CRC, never in flags
	task pbyte(input logic [7:0] v, input logic st);
		for (int i = 0; i < 8; i++) begin
			e_v[e_n] = v[i];
			e_n++;
			ones = (st && v[i]) ? ones + 1 : 0;
			if (ones == 5) begin
				e_v[e_n] = 1'b0;
				e_n++;
				ones = 0;
			end
		end
	endtask

	task build(input fdl_row_type x);
		e_n = 0;
		e_v = '0;
		ones = 0;
		for (int k = 0; k < x.reps; k++) begin
			crc = `FDL_CRC_INIT;
			if (x.kind != 0)
				pbyte(`FDL_FLAG, 1'b0);
			for (int i = 0; i < x.nb; i++) begin
				b = x.word[8*i+:8];
				pbyte(b, x.kind != 0);
				for (int j = 0; j < 8; j++) begin
					fb = b[j] ^ crc[0];
					crc = crc >> 1;
					if (fb)
						crc = crc ^ `FDL_CRC_POLY;
				end
			end
			crc = ~crc;
			if (x.kind == 1 && x.ctrl) begin
				pbyte(crc[7:0], 1'b1);
				pbyte(crc[15:8], 1'b1);
			end
			if (x.kind == 1)
				pbyte(`FDL_FLAG, 1'b0);
			if (x.kind == 2)
				pbyte(`FDL_ABORT_SEQ, 1'b0);
		end
	endtask

	task final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog well beyond the expected run of some 4150 cycles
	initial begin
		#200000;
		mismatches++;
		final_report;
	end

	initial begin
		// Command, word, crc, bytes out, kind, reps, exact, level
		rows[0] = '{16'h0003, 16'h02a5, 1, 2, 0, 1, 1, 0};
		rows[1] = '{16'h000b, 16'h77c3, 1, 1, 0, 1, 1, 0};
		rows[2] = '{16'h0005, 16'h00fc, 1, 1, 1, 1, 1, 0};
		rows[3] = '{16'h0005, 16'h01fc, 1, 1, 2, 1, 0, 0};
		rows[4] = '{16'h0005, 16'h003c, 0, 1, 1, 1, 1, 0};
		rows[5] = '{16'h0012, 16'h3c5a, 1, 2, 0, 2, 0, 1};
		rows[6] = '{16'h0014, 16'h81ff, 1, 2, 1, 2, 0, 1};
		rows[7] = '{16'h0103, 16'h02a5, 1, 0, 0, 1, 1, 1};
		rows[8] = '{16'h0023, 16'h02a5, 1, 0, 0, 1, 1, 0};
		rows[9] = '{16'h0006, 16'h1234, 1, 0, 0, 1, 1, 1};
		stp = '{16'h0012, 16'h0014};
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`FDL_OFS_STAT, rv);
		`CHK("stat", 16'h0000, rv)
		rd(`FDL_OFS_CTRL, rv);
		`CHK("ctrl", 16'h0001, rv)
		@(posedge clk_sys);
		#1 `CHK("stand", 16'h0000, reg_rdata)
		rd(`FDL_OFS_CMD, rv);
		`CHK("cmd", 16'h0000, rv)
		rd(8'h05, rv);
		`CHK("unmapped", 16'h0000, rv)
		`CHK("ready", 1'b1, tx_fifo_ready)
		// Table of command rows, each ended by a transmitter reset
		foreach (rows[i]) begin
			r = rows[i];
			wr(`FDL_OFS_CTRL, {15'h0000, r.ctrl});
			wr(`FDL_OFS_FIFO, r.word);
			clr;
			wr(`FDL_OFS_CMD, r.cmd);
			coll(300);
			build(r);
			`CHK("bits", e_v, c_v & ((128'h1 << e_n) - 1))
			if (r.ex)
				`CHK("count", e_n, c_n)
			`CHK("rx", r.cmd[8] ? 1 : 0, rx_cnt)
			rd(`FDL_OFS_STAT, rv);
			`CHK("level", r.lvl, rv[13:8])
			wr(`FDL_OFS_CMD, 16'h0020);
			rd(`FDL_OFS_STAT, rv);
			`CHK("tx_reset_cmd", 16'h0000, rv)
			rd(`FDL_OFS_CTRL, rv);
			`CHK("kept", {15'h0000, r.ctrl}, rv)
		end
		// Stop of both repeat kinds; line must fall silent
		foreach (stp[i]) begin
			wr(`FDL_OFS_FIFO, 16'h00a5);
			wr(`FDL_OFS_CMD, stp[i]);
			coll(40);
			wr(`FDL_OFS_CMD, stp[i] | 16'h0001);
			coll(300);
			clr;
			coll(40);
			`CHK("stop", 0, c_n)
			wr(`FDL_OFS_CMD, 16'h0020);
		end
		// Abort in mid-frame; seven ones only occur in the abort
		wr(`FDL_OFS_CTRL, 16'h0001);
		wr(`FDL_OFS_FIFO, 16'h1111);
		wr(`FDL_OFS_FIFO, 16'h2222);
		wr(`FDL_OFS_CMD, 16'h0004);
		coll(20);
		clr;
		wr(`FDL_OFS_CMD, 16'h0040);
		coll(60);
		seen = 1'b0;
		for (int k = 0; k + 6 < c_n && k < 121; k++)
			if (c_v[k+:7] === 7'h7f)
				seen = 1'b1;
		`CHK("abort", 1'b1, seen)
		rd(`FDL_OFS_STAT, rv);
		`CHK("flushed", 6'd0, rv[13:8])
		// Fill past depth; the extra word must be dropped
		for (int k = 0; k < 33; k++)
			wr(`FDL_OFS_FIFO, k[15:0]);
		#1 `CHK("full", 1'b0, tx_fifo_ready)
		rd(`FDL_OFS_STAT, rv);
		`CHK("lvl32", 7'h41, {rv[13:8], rv[5]})
		wr(`FDL_OFS_CMD, 16'h0020);
		#1 `CHK("empty", 1'b1, tx_fifo_ready)
		final_report;
	end
endmodule
